//--- verilog/energy_regs_cfg.svh
`ifndef ENERGY_REGS_CFG_SVH
`define ENERGY_REGS_CFG_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_IRQ_MASK_ZERO    10'h0d0
`define IDX_IRQ_MASK_ONE     10'h0d1
`define IDX_CRC_OPTS         10'h0db
`define IDX_CRC_FORCE        10'h0dc
`define IDX_WRITE_LOCK       10'h0dd
`define IDX_STATUS_TWO       10'h0e0
`define IDX_IRQ_CLEAR        10'h0e1
`define IDX_IRQ_ENABLE       10'h0e2
`define IDX_CRC_RESULT       10'h0e3
`define IDX_A_POS_LO         10'h257
`define IDX_A_NEG_LO         10'h259
`define IDX_A_SGN_LO         10'h25b
`define IDX_A_APP_LO         10'h25d
`define IDX_B_POS_LO         10'h262
`define IDX_B_NEG_LO         10'h264
`define IDX_B_SGN_LO         10'h266
`define IDX_B_APP_LO         10'h268
`define IDX_C_POS_LO         10'h26d
`define IDX_C_NEG_LO         10'h26f
`define IDX_C_SGN_LO         10'h271
`define IDX_C_APP_LO         10'h273
`define IDX_HI_STEP          10'h001

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define BIT_INCL_MASK_ZERO   0
`define BIT_INCL_MASK_ONE    1
`define BIT_FORCE            0
`define BIT_LOCK             0
`define BIT_CRC_DONE         0
`define BIT_LOCKED_WRITE     1
`define LOW_WIDTH            13
`define ACC_WIDTH            45
`define EVENT_COUNT          2
`define RESET_WORD           32'h0000_0000
`define CRC_POLY             32'h04c1_1db7
`define CRC_SEED             32'hffff_ffff
`define CRC_WORDS            2'h3

`endif

//--- verilog/energy_regs_pkg.sv
package energy_regs_pkg;
	typedef enum logic {CRC_IDLE, CRC_RUN} crc_state_t;
	typedef logic [44:0] acc_t;
	typedef logic [9:0]  reg_idx_t;
endpackage

//--- verilog/energy_phase_acc.sv
`timescale 1ns/1ps
`default_nettype none
`include "energy_regs_cfg.svh"

module energy_phase_acc (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  sample_valid,
	input  wire logic signed [31:0]    act_pwr,
	input  wire logic        [31:0]    app_pwr,
	output var  energy_regs_pkg::acc_t pos_acc,
	output var  energy_regs_pkg::acc_t neg_acc,
	output var  energy_regs_pkg::acc_t sgn_acc,
	output var  energy_regs_pkg::acc_t app_acc
);
	import energy_regs_pkg::*;

	acc_t next_pos, next_neg, next_sgn, next_app;
	acc_t act_ext;

	// accumulators wrap modulo 2^45, as the meter counters do
	always_comb begin
		act_ext  = {{13{act_pwr[31]}}, act_pwr};
		next_pos = pos_acc;
		next_neg = neg_acc;
		next_sgn = sgn_acc;
		next_app = app_acc;
		if (sample_valid) begin
			if (act_pwr > 0)
				next_pos = pos_acc + act_ext;  // see R6
			if (act_pwr < 0)
				next_neg = neg_acc - act_ext;  // see R7
			next_sgn = sgn_acc + act_ext;      // see R8
			next_app = app_acc + {13'h0, app_pwr}; // see R9
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_acc <= 45'h0;
			neg_acc <= 45'h0;
			sgn_acc <= 45'h0;
			app_acc <= 45'h0;
		end else begin
			pos_acc <= next_pos;
			neg_acc <= next_neg;
			sgn_acc <= next_sgn;
			app_acc <= next_app;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_pos_only;
		sample_valid && act_pwr > 0 |=>
			pos_acc == $past(pos_acc) + $past(act_ext)
			&& neg_acc == $past(neg_acc);
	endproperty
	a_pos_only: assert property (p_pos_only) // see R6
		else $error("positive energy not accumulated");

	property p_neg_only;
		sample_valid && act_pwr < 0 |=>
			neg_acc == $past(neg_acc) - $past(act_ext)
			&& pos_acc == $past(pos_acc);
	endproperty
	a_neg_only: assert property (p_neg_only) // see R7
		else $error("negative energy not accumulated");

	property p_signed;
		sample_valid |=> sgn_acc == $past(sgn_acc) + $past(act_ext);
	endproperty
	a_signed: assert property (p_signed) // see R8
		else $error("signed energy mismatch");

	property p_apparent;
		!sample_valid |=> $stable(app_acc) && $stable(sgn_acc);
	endproperty
	a_apparent: assert property (p_apparent) // see R9
		else $error("accumulator moved without a sample");
endmodule
`default_nettype wire

//--- verilog/config_crc_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "energy_regs_cfg.svh"

module config_crc_engine (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        start,
	input  wire logic        incl_mask_zero,
	input  wire logic        incl_mask_one,
	input  wire logic [31:0] opts_word,
	input  wire logic [31:0] mask_zero_word,
	input  wire logic [31:0] mask_one_word,
	output var  logic        busy,
	output var  logic        done,
	output var  logic [31:0] crc_value
);
	import energy_regs_pkg::*;

	crc_state_t  state, next_state;
	logic [31:0] crc, next_crc, sh, next_sh;
	logic [31:0] wbuf [3];
	logic [31:0] next_wbuf [3];
	logic [1:0]  widx, next_widx;
	logic [4:0]  bitcnt, next_bitcnt;
	logic [1:0]  incl, next_incl;
	logic        next_done, fb;

	// word 0 is the options word, always covered; masks are optional
	function automatic logic covered(input logic [1:0] i,
	                                 input logic [1:0] en);
		covered = (i == 2'h0) || (i == 2'h1 && en[0]) ||
		          (i == 2'h2 && en[1]);
	endfunction

	always_comb begin
		next_state  = state;
		next_crc    = crc;
		next_sh     = sh;
		next_widx   = widx;
		next_bitcnt = bitcnt;
		next_incl   = incl;
		next_wbuf   = wbuf;
		next_done   = 1'b0;
		fb          = crc[31] ^ sh[31];
		// a start while running restarts from the seed
		if (start) begin
			next_state  = CRC_RUN;
			next_crc    = `CRC_SEED;
			next_wbuf   = '{opts_word, mask_zero_word, mask_one_word};
			next_sh     = opts_word;
			next_widx   = 2'h0;
			next_bitcnt = 5'h0;
			next_incl   = {incl_mask_one, incl_mask_zero}; // see R1
		end else if (state == CRC_RUN) begin
			if (bitcnt == 5'h0 && !covered(widx, incl)) begin
				next_bitcnt = 5'h1f; // see R1
			end else begin
				next_crc = {crc[30:0], 1'b0} ^ (fb ? `CRC_POLY : 32'h0);
				next_sh  = {sh[30:0], 1'b0};
			end
			next_bitcnt = (bitcnt == 5'h1f) ? 5'h0 : bitcnt + 5'h1;
			if (bitcnt == 5'h1f || (bitcnt == 5'h0 &&
			    !covered(widx, incl))) begin
				next_bitcnt = 5'h0;
				if (widx == `CRC_WORDS - 2'h1) begin
					next_state = CRC_IDLE;
					next_done  = 1'b1;
				end else begin
					next_widx = widx + 2'h1;
					next_sh   = wbuf[widx + 2'h1];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state  <= CRC_IDLE;
			crc    <= `RESET_WORD;
			sh     <= `RESET_WORD;
			widx   <= 2'h0;
			bitcnt <= 5'h0;
			incl   <= 2'h0;
			done   <= 1'b0;
			for (int i = 0; i < 3; i++)
				wbuf[i] <= `RESET_WORD;
		end else begin
			state  <= next_state;
			crc    <= next_crc;
			sh     <= next_sh;
			widx   <= next_widx;
			bitcnt <= next_bitcnt;
			incl   <= next_incl;
			done   <= next_done;
			wbuf   <= next_wbuf;
		end
	end

	assign busy      = (state == CRC_RUN);
	assign crc_value = crc;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_skip_excluded;
		state == CRC_RUN && bitcnt == 5'h0 && !start
			&& !covered(widx, incl) |=> $stable(crc);
	endproperty
	a_skip_excluded: assert property (p_skip_excluded) // see R1
		else $error("excluded mask word entered the checksum");
endmodule
`default_nettype wire

//--- verilog/config_crc_lock_energy_regs.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "energy_regs_cfg.svh"

// Function
// (R1) crc covers each interrupt mask only when its inclusion bit is set; bits reset 0
// (R2) writing force bit 0 starts a fresh configuration crc run
// (R3) a forced run that finishes sets the done flag in status two
// (R4) while lock bit is set, writes to the masks, crc options and irq enable are ignored; force, clear and lock writes still act
// (R5) low energy words show accumulator bits 12..0; upper bits read zero
// (R6) each phase keeps its own positive active energy accumulator
// (R7) each phase keeps its own negative active energy accumulator
// (R8) each phase keeps a signed active energy accumulator
// (R9) each phase keeps an apparent energy accumulator, low 13 bits readable
// (R10) high word shows accumulator bits 44..13 across all 32 bits
// (R11) high word read returns the snapshot taken at the low word read
module config_crc_lock_energy_regs (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        irq,
	input  wire logic [2:0]  sample_valid,
	input  wire logic [31:0] act_pwr_a,
	input  wire logic [31:0] act_pwr_b,
	input  wire logic [31:0] act_pwr_c,
	input  wire logic [31:0] app_pwr_a,
	input  wire logic [31:0] app_pwr_b,
	input  wire logic [31:0] app_pwr_c
);
	import energy_regs_pkg::*;

	// ------------------------------------------------------------
	// energy accumulators, slot = phase * 4 + kind
	// ------------------------------------------------------------
	localparam reg_idx_t LO_TBL [12] = '{
		`IDX_A_POS_LO, `IDX_A_NEG_LO, `IDX_A_SGN_LO, `IDX_A_APP_LO,
		`IDX_B_POS_LO, `IDX_B_NEG_LO, `IDX_B_SGN_LO, `IDX_B_APP_LO,
		`IDX_C_POS_LO, `IDX_C_NEG_LO, `IDX_C_SGN_LO, `IDX_C_APP_LO};

	acc_t        acc [12];
	logic [31:0] act_in [3];
	logic [31:0] app_in [3];

	assign act_in = '{act_pwr_a, act_pwr_b, act_pwr_c};
	assign app_in = '{app_pwr_a, app_pwr_b, app_pwr_c};

	for (genvar p = 0; p < 3; p++) begin : g_phase
		energy_phase_acc u_acc (
			.pclk         (pclk),
			.presetn      (presetn),
			.sample_valid (sample_valid[p]),
			.act_pwr      (act_in[p]),
			.app_pwr      (app_in[p]),
			.pos_acc      (acc[p*4]),
			.neg_acc      (acc[p*4+1]),
			.sgn_acc      (acc[p*4+2]),
			.app_acc      (acc[p*4+3])
		);
	end

	// returns {hit, high word, slot}
	function automatic logic [5:0] energy_slot(input reg_idx_t idx);
		energy_slot = 6'h00;
		for (int s = 0; s < 12; s++) begin
			if (idx == LO_TBL[s])
				energy_slot = {2'b10, s[3:0]};
			if (idx == LO_TBL[s] + `IDX_HI_STEP)
				energy_slot = {2'b11, s[3:0]};
		end
	endfunction

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [1:0]  crc_incl, next_crc_incl;
	logic [31:0] mask_zero, next_mask_zero;
	logic [31:0] mask_one, next_mask_one;
	logic        lock, next_lock;
	logic [1:0]  status, next_status;
	logic [1:0]  irq_en, next_irq_en;
	logic        crc_start, next_crc_start;
	logic        forced, next_forced;
	logic [31:0] snap [12];
	logic [31:0] next_snap [12];
	logic [31:0] next_prdata;
	logic        next_pready, next_pslverr, next_irq;
	logic [3:0]  rd_slot, next_rd_slot;
	logic        rd_hi, next_rd_hi;

	logic        crc_busy, crc_done;
	logic [31:0] crc_value;

	reg_idx_t    idx;
	logic [5:0]  eslot;
	logic        aligned, mapped, wr_ok, cfg_tgt, locked_wr;
	logic [1:0]  events, clr;

	config_crc_engine u_crc (
		.pclk           (pclk),
		.presetn        (presetn),
		.start          (crc_start),
		.incl_mask_zero (crc_incl[`BIT_INCL_MASK_ZERO]),
		.incl_mask_one  (crc_incl[`BIT_INCL_MASK_ONE]),
		.opts_word      ({30'h0, crc_incl}),
		.mask_zero_word (mask_zero),
		.mask_one_word  (mask_one),
		.busy           (crc_busy),
		.done           (crc_done),
		.crc_value      (crc_value)
	);

	// ------------------------------------------------------------
	// apb decode and register next values
	// ------------------------------------------------------------
	// access phase is two cycles: pready rises in the second one
	always_comb begin
		idx     = paddr[11:2];
		aligned = (paddr[1:0] == 2'h0);
		eslot   = energy_slot(idx);
		unique case (idx)
			`IDX_IRQ_MASK_ZERO, `IDX_IRQ_MASK_ONE, `IDX_CRC_OPTS,
			`IDX_CRC_FORCE, `IDX_WRITE_LOCK, `IDX_STATUS_TWO,
			`IDX_IRQ_CLEAR, `IDX_IRQ_ENABLE, `IDX_CRC_RESULT:
				mapped = aligned;
			default: mapped = aligned && eslot[5];
		endcase
		cfg_tgt = (idx == `IDX_IRQ_MASK_ZERO) ||
		          (idx == `IDX_IRQ_MASK_ONE) ||
		          (idx == `IDX_CRC_OPTS) || (idx == `IDX_IRQ_ENABLE);
		wr_ok     = psel && penable && pready && pwrite && mapped;
		// lock itself stays writable so software can unlock
		locked_wr = wr_ok && cfg_tgt && lock; // see R4

		next_crc_incl  = crc_incl;
		next_mask_zero = mask_zero;
		next_mask_one  = mask_one;
		next_lock      = lock;
		next_irq_en    = irq_en;
		next_crc_start = 1'b0;
		next_forced    = forced;
		clr            = 2'h0;
		// a done seen while a restart is queued belongs to the old run
		if (crc_done && !crc_start)
			next_forced = 1'b0;
		if (wr_ok && !locked_wr) begin // see R4
			unique case (idx)
				`IDX_CRC_OPTS:
					next_crc_incl = pwdata[1:0]; // see R1
				`IDX_IRQ_MASK_ZERO: next_mask_zero = pwdata;
				`IDX_IRQ_MASK_ONE:  next_mask_one  = pwdata;
				`IDX_WRITE_LOCK:    next_lock = pwdata[`BIT_LOCK];
				`IDX_IRQ_ENABLE:
					next_irq_en = pwdata[`EVENT_COUNT-1:0];
				`IDX_IRQ_CLEAR:
					clr = pwdata[`EVENT_COUNT-1:0];
				`IDX_CRC_FORCE: begin
					next_crc_start = pwdata[`BIT_FORCE]; // see R2
					next_forced    = pwdata[`BIT_FORCE] | next_forced;
				end
				default: ;
			endcase
			// configuration changes refresh the checksum on their own
			if (cfg_tgt && idx != `IDX_IRQ_ENABLE)
				next_crc_start = 1'b1;
		end
		// a new event wins over a clear in the same cycle
		events = {locked_wr, crc_done && forced && !crc_start}; // see R3
		next_status = (status & ~clr) | events;
		next_irq    = |(next_status & next_irq_en);

		next_pready  = psel && penable && !pready;
		next_pslverr = next_pready && !mapped;
		next_prdata  = `RESET_WORD;
		next_snap    = snap;
		next_rd_slot = rd_slot;
		next_rd_hi   = rd_hi;
		if (next_pready && !pwrite && mapped) begin
			next_rd_slot = eslot[3:0];
			next_rd_hi   = eslot[4];
			unique case (idx)
				`IDX_CRC_OPTS:      next_prdata = {30'h0, crc_incl};
				`IDX_IRQ_MASK_ZERO: next_prdata = mask_zero;
				`IDX_IRQ_MASK_ONE:  next_prdata = mask_one;
				`IDX_CRC_FORCE:     next_prdata = {31'h0, crc_busy};
				`IDX_WRITE_LOCK:    next_prdata = {31'h0, lock};
				`IDX_STATUS_TWO:    next_prdata = {30'h0, status};
				`IDX_IRQ_ENABLE:    next_prdata = {30'h0, irq_en};
				// write-only: must not fall into the energy path
				`IDX_IRQ_CLEAR:     next_prdata = `RESET_WORD;
				`IDX_CRC_RESULT:    next_prdata = crc_value;
				default: begin
					if (eslot[4]) begin
						next_prdata = snap[eslot[3:0]]; // see R11
					end else begin
						// see R5
						next_prdata = {19'h0,
							acc[eslot[3:0]][`LOW_WIDTH-1:0]};
						// see R10
						next_snap[eslot[3:0]] =
							acc[eslot[3:0]][`ACC_WIDTH-1:`LOW_WIDTH];
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_incl  <= 2'h0;
			mask_zero <= `RESET_WORD;
			mask_one  <= `RESET_WORD;
			lock      <= 1'b0;
			status    <= 2'h0;
			irq_en    <= 2'h0;
			crc_start <= 1'b0;
			forced    <= 1'b0;
			prdata    <= `RESET_WORD;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			irq       <= 1'b0;
			rd_slot   <= 4'h0;
			rd_hi     <= 1'b0;
			for (int s = 0; s < 12; s++)
				snap[s] <= `RESET_WORD;
		end else begin
			crc_incl  <= next_crc_incl;
			mask_zero <= next_mask_zero;
			mask_one  <= next_mask_one;
			lock      <= next_lock;
			status    <= next_status;
			irq_en    <= next_irq_en;
			crc_start <= next_crc_start;
			forced    <= next_forced;
			prdata    <= next_prdata;
			pready    <= next_pready;
			pslverr   <= next_pslverr;
			irq       <= next_irq;
			rd_slot   <= next_rd_slot;
			rd_hi     <= next_rd_hi;
			snap      <= next_snap;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_lock_hold;
		wr_ok && lock && idx == `IDX_IRQ_MASK_ZERO |=>
			$stable(mask_zero) && status[`BIT_LOCKED_WRITE];
	endproperty
	a_lock_hold: assert property (p_lock_hold) // see R4
		else $error("locked write changed a mask register");

	property p_force_start;
		wr_ok && !locked_wr && idx == `IDX_CRC_FORCE
			&& pwdata[`BIT_FORCE] |-> ##2 crc_busy;
	endproperty
	a_force_start: assert property (p_force_start) // see R2
		else $error("forced checksum run did not start");

	property p_done_flag;
		crc_done && forced && !crc_start |=>
			status[`BIT_CRC_DONE] ##1 irq == irq_en[0];
	endproperty
	a_done_flag: assert property (p_done_flag) // see R3
		else $error("forced run finished without done flag");

	property p_low_word;
		pready && !pwrite && !pslverr && !rd_hi && psel
			&& energy_slot(idx) == {2'b10, rd_slot}
			|-> prdata[31:`LOW_WIDTH] == 19'h0;
	endproperty
	a_low_word: assert property (p_low_word) // see R5
		else $error("upper bits of a low energy word not zero");

	property p_high_word;
		pready && !pwrite && rd_hi && psel
			&& energy_slot(idx) == {2'b11, rd_slot}
			|-> prdata == snap[rd_slot];
	endproperty
	a_high_word: assert property (p_high_word) // see R11
		else $error("high word differs from its snapshot");

	c_force_done: cover property (crc_start ##[1:200] crc_done);
	c_locked_wr:  cover property (locked_wr);
	c_lo_then_hi: cover property (pready && !rd_hi ##[2:20] pready && rd_hi);
endmodule
`default_nettype wire

//--- bench/config_crc_lock_energy_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "energy_regs_cfg.svh"

module config_crc_lock_energy_regs_bench;
	import energy_regs_pkg::*;

	typedef struct {
		string       name;
		logic [31:0] data;
		logic        err;
	} note_t;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [2:0]  sample_valid;
	logic [31:0] act [3];
	logic [31:0] app [3];
	note_t       notes [$];
	note_t       cur;
	acc_t        acc [12];
	reg_idx_t    lows [12];
	int          miscompares;
	int          check_count;
	int          seed;
	logic [31:0] irq_mask_reg_zero;
	logic [31:0] irq_mask_reg_one;
	logic [31:0] crc;
	logic [12:0] snap_lo;
	logic [31:0] snap_hi;

	config_crc_lock_energy_regs dut_u (
		.pclk        (pclk),
		.presetn     (presetn),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.irq         (irq),
		.sample_valid(sample_valid),
		.act_pwr_a   (act[0]),
		.act_pwr_b   (act[1]),
		.act_pwr_c   (act[2]),
		.app_pwr_a   (app[0]),
		.app_pwr_b   (app[1]),
		.app_pwr_c   (app[2])
	);

	// ----------------------------------------
	// clock, checking and closing
	// ----------------------------------------
	always #4 pclk = ~pclk;

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// each completed transfer answers the oldest note
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (notes.size() == 0) begin
				check("unexpected answer", 32'h1, 32'h0);
			end else begin
				cur = notes.pop_front();
				check(cur.name, prdata, cur.data);
				check({cur.name, " error"}, {31'h0, pslverr}, {31'h0, cur.err});
			end
		end
	end

	// ----------------------------------------
	// apb master
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] d, input logic [31:0] exp,
			input logic err, input string name);
		int k;
		k = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		notes.push_back('{name, exp, err});
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 30);
		if (k >= 30)
			check("pready timeout", 32'h1, 32'h0);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input reg_idx_t i, input logic [31:0] d);
		apb(1'b1, {i, 2'b00}, d, 32'h0, 1'b0, "write");
	endtask

	task automatic rd(input reg_idx_t i, input logic [31:0] exp, input string nm);
		apb(1'b0, {i, 2'b00}, 32'h0, exp, 1'b0, nm);
	endtask

	function automatic logic [31:0] crc_word(input logic [31:0] c,
			input logic [31:0] w);
		logic fb;
		for (int i = 31; i >= 0; i--) begin
			fb = c[31] ^ w[i];
			c  = {c[30:0], 1'b0};
			if (fb)
				c = c ^ `CRC_POLY;
		end
		return c;
	endfunction

	// strobes are spaced by an idle cycle so each stays a single pulse
	task automatic samples(input int n);
		logic [31:0] a;
		logic [44:0] s;
		logic [2:0]  v;
		repeat (n) begin
			@(posedge pclk);
			v = 3'($random(seed));
			sample_valid <= v;
			for (int p = 0; p < 3; p++) begin
				a = $random(seed);
				act[p] <= a;
				app[p] <= 32'($random(seed));
				s = {{13{a[31]}}, a};
				if (v[p]) begin
					if (!a[31] && a != 32'h0)
						acc[p*4] = acc[p*4] + s;
					if (a[31])
						acc[p*4+1] = acc[p*4+1] - s;
					acc[p*4+2] = acc[p*4+2] + s;
				end
			end
			#1;
			for (int p = 0; p < 3; p++)
				if (v[p])
					acc[p*4+3] = acc[p*4+3] + {13'h0, app[p]};
			@(posedge pclk);
			sample_valid <= 3'h0;
		end
	endtask

	initial begin
		repeat (30000) @(posedge pclk);
		miscompares++;
		tally_and_finish();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = 12'h0; pwdata = 32'h0; sample_valid = 3'h0;
		miscompares = 0; check_count = 0; seed = 32'h551c;
		lows = '{`IDX_A_POS_LO, `IDX_A_NEG_LO, `IDX_A_SGN_LO, `IDX_A_APP_LO,
			`IDX_B_POS_LO, `IDX_B_NEG_LO, `IDX_B_SGN_LO, `IDX_B_APP_LO,
			`IDX_C_POS_LO, `IDX_C_NEG_LO, `IDX_C_SGN_LO, `IDX_C_APP_LO};
		for (int p = 0; p < 3; p++) begin
			act[p] = 32'h0;
			app[p] = 32'h0;
		end
		for (int i = 0; i < 12; i++)
			acc[i] = 45'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;

		rd(`IDX_CRC_OPTS, 32'h0, "opts reset");
		rd(`IDX_CRC_FORCE, 32'h0, "force reset");
		rd(`IDX_WRITE_LOCK, 32'h0, "lock reset");
		rd(`IDX_STATUS_TWO, 32'h0, "status reset");
		rd(`IDX_A_POS_LO, 32'h0, "low reset");
		rd(`IDX_A_POS_LO + 10'h1, 32'h0, "high reset");
		apb(1'b0, 12'hffc, 32'h0, 32'h0, 1'b1, "unmapped read");
		apb(1'b1, 12'hffc, 32'h5, 32'h0, 1'b1, "unmapped write");
		apb(1'b0, 12'h36d, 32'h0, 32'h0, 1'b1, "misaligned read");
		check("irq after reset", {31'h0, irq}, 32'h0);
		$display("test reset and map done");

		// forced crc for every pair of inclusion bits
		irq_mask_reg_zero = $random(seed);
		irq_mask_reg_one = $random(seed);
		wr(`IDX_IRQ_MASK_ZERO, irq_mask_reg_zero);
		wr(`IDX_IRQ_MASK_ONE, irq_mask_reg_one);
		wr(`IDX_IRQ_ENABLE, 32'h3);
		for (int en = 0; en < 4; en++) begin
			wr(`IDX_CRC_OPTS, 32'(en));
			repeat (110) @(posedge pclk);
			wr(`IDX_CRC_FORCE, 32'h1);
			for (int k = 0; k < 150 && irq !== 1'b1; k++)
				@(posedge pclk);
			check("irq on done", {31'h0, irq}, 32'h1);
			rd(`IDX_STATUS_TWO, 32'h1, "status done");
			crc = crc_word(`CRC_SEED, 32'(en));
			if (en[0])
				crc = crc_word(crc, irq_mask_reg_zero);
			if (en[1])
				crc = crc_word(crc, irq_mask_reg_one);
			rd(`IDX_CRC_RESULT, crc, "crc value");
			wr(`IDX_IRQ_CLEAR, 32'h1);
			@(posedge pclk);
			check("irq cleared", {31'h0, irq}, 32'h0);
		end
		$display("test crc inclusion done");

		// lock blocks configuration writes and flags the attempt
		wr(`IDX_WRITE_LOCK, 32'h1);
		rd(`IDX_WRITE_LOCK, 32'h1, "lock set");
		wr(`IDX_CRC_OPTS, 32'h0);
		wr(`IDX_IRQ_ENABLE, 32'h0);
		wr(`IDX_IRQ_MASK_ZERO, ~irq_mask_reg_zero);
		rd(`IDX_CRC_OPTS, 32'h3, "opts locked");
		rd(`IDX_STATUS_TWO, 32'h2, "locked attempt");
		check("irq locked attempt", {31'h0, irq}, 32'h1);
		wr(`IDX_WRITE_LOCK, 32'h0);
		rd(`IDX_WRITE_LOCK, 32'h0, "lock clear");
		wr(`IDX_IRQ_CLEAR, 32'h3);
		wr(`IDX_IRQ_ENABLE, 32'h0);
		repeat (110) @(posedge pclk);
		wr(`IDX_CRC_FORCE, 32'h1);
		repeat (110) @(posedge pclk);
		check("irq masked", {31'h0, irq}, 32'h0);
		rd(`IDX_STATUS_TWO, 32'h1, "masked done");
		crc = crc_word(crc_word(crc_word(`CRC_SEED, 32'h3), irq_mask_reg_zero), irq_mask_reg_one);
		rd(`IDX_CRC_RESULT, crc, "crc after lock");
		wr(`IDX_IRQ_CLEAR, 32'h3);
		$display("test lock done");

		// energy accumulators, split words and snapshot
		samples(40);
		wr(`IDX_A_POS_LO, 32'hffff_ffff);
		rd(`IDX_IRQ_CLEAR, 32'h0, "clear reads zero");
		for (int i = 0; i < 12; i++) begin
			rd(lows[i], {19'h0, acc[i][12:0]}, "energy low");
			rd(lows[i] + 10'h1, acc[i][44:13], "energy high");
		end
		snap_lo = acc[2][12:0];
		snap_hi = acc[2][44:13];
		rd(lows[2], {19'h0, snap_lo}, "snapshot low");
		samples(5);
		rd(lows[2] + 10'h1, snap_hi, "snapshot high");
		for (int i = 0; i < 12; i++)
			rd(lows[i], {19'h0, acc[i][12:0]}, "energy low again");
		$display("test energy done");

		repeat (4) @(posedge pclk);
		check("pending notes", 32'(notes.size()), 32'h0);
		tally_and_finish();
	end
endmodule

`default_nettype wire
